// ---- aesr_pkg.sv ----
// package for application error and slot event request registers
package aesr_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_ERR_CTRL   = 8'h10;
   localparam logic [7:0] OFS_ERR_ATTR   = 8'h14;
   localparam logic [7:0] OFS_ERR_HDR0   = 8'h18;
   localparam logic [7:0] OFS_ERR_HDR1   = 8'h1C;
   localparam logic [7:0] OFS_ERR_HDR2   = 8'h20;
   localparam logic [7:0] OFS_ERR_HDR3   = 8'h24;
   localparam logic [7:0] OFS_ERR_PREFIX = 8'h28;
   localparam logic [7:0] OFS_SLOT_EVENT = 8'h2C;

   // writable-bit masks; reserved bits read zero
   localparam logic [31:0] MASK_ERR_CTRL  = 32'h7DFF_DF87;
   localparam logic [31:0] MASK_ERR_ATTR  = 32'h0000_3FFF;
   localparam logic [31:0] MASK_SLOT_EVT  = 32'h0000_3FFF;
   localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

   // control field positions
   localparam int CTRL_TRIGGER     = 0;
   localparam int CTRL_LOG_HEADER  = 1;
   localparam int CTRL_LOG_PREFIX  = 2;
   localparam int CTRL_VIRTUAL_FUNCTION_ACTIVE   = 7;
   localparam int CTRL_PF_LSB      = 8;
   localparam int CTRL_PF_MSB      = 12;
   localparam int CTRL_VF_LSB      = 14;
   localparam int CTRL_VF_MSB      = 24;
   localparam int CTRL_SLOT_LSB    = 26;
   localparam int CTRL_SLOT_MSB    = 30;

   // attribute bit positions
   localparam int ATTR_ADVISORY    = 0;
   localparam int ATTR_UNEXP_CPL   = 1;
   localparam int ATTR_CPL_ABORT   = 2;
   localparam int ATTR_CPL_TIMEOUT = 3;
   localparam int ATTR_UNSUP_REQ   = 4;
   localparam int ATTR_POISON_RX   = 5;
   localparam int ATTR_ECRC        = 6;
   localparam int ATTR_ATOMIC_BLK  = 7;
   localparam int ATTR_UNCOR_INT   = 8;
   localparam int ATTR_COR_INT     = 9;
   localparam int ATTR_PREFIX_BLK  = 10;
   localparam int ATTR_ACS_VIOL    = 11;
   localparam int ATTR_MC_BLK      = 12;
   localparam int ATTR_POISON_EGR  = 13;
   localparam int ATTR_WIDTH       = 14;

   // attribute bits forwarded in this release
   localparam logic [13:0] ATTR_SUPPORTED = 14'h003F;

   // slot event bit count and slot number field
   localparam int SLOT_EVT_COUNT   = 5;
   localparam int SLOT_NUM_LSB     = 9;
   localparam int SLOT_NUM_MSB     = 13;

   typedef struct packed {
      logic [4:0]  slot_number;
      logic [10:0] virtual_function_index;
      logic        virtual_function_active;
      logic [4:0]  physical_function_index;
      logic        log_prefix;
      logic        log_header;
      logic [13:0] error_type_attributes;
      logic [127:0] error_header_dword;
      logic [31:0] error_prefix_word;
   } aesr_err_req_t;

   typedef struct packed {
      logic [4:0] slot_number;
      logic [4:0] events;
   } aesr_slot_req_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_WAIT = 2'b11
   } aesr_state_t;

endpackage

// ---- aesr_slot_event.sv ----
// one self-clearing slot event request bit with core handshake
module aesr_slot_event (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   // register side
   input  wire logic i_set,
   input  wire logic i_clear,
   // core side
   input  wire logic i_ack,
   output logic      o_req
);

   logic next_req;

   // set wins over completion clear
   assign next_req = i_set | (o_req & ~i_ack & ~i_clear);

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_req <= 1'b0;
      end else begin
         o_req <= next_req;
      end
   end

endmodule

// ---- aesr_regs.sv ----
// application error and slot event request register bank
// Summary of operation
// - vf index bits 24:14, valid with virtual_function_active
// - slot number bits 30:26; 13,25,31 zero
// - attribute bit 0 marks error advisory
// - bit 1 reports unexpected completion
// - bit 2 reports completer abort
// - bit 3 reports completion timeout
// - bit 4 reports unsupported request
// - bit 5 reports poisoned request received
// - bits 6,7 defined, not forwarded
// - bits 8,12,13 defined, not forwarded
// - bit 9 defined, not forwarded
// - bits 10,11 defined, not forwarded
// - four header dwords hold logged header
// - prefix word held, forwarded copy stable while request asserted
// - slot bit 0 forwarded then cleared
// - slot bit 1 forwarded then cleared
// - slot bit 2 forwarded then cleared
// - slot bit 3 forwarded then cleared
// - slot bit 4 forwarded then cleared
// - trigger starts report, cleared when done
module aesr_regs (
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_reset,
   // register port
   input  wire logic                   i_reg_write,
   input  wire logic                   i_reg_read,
   input  wire logic [7:0]             i_reg_addr,
   input  wire logic [31:0]            i_reg_wdata,
   output logic [31:0]                 o_reg_rdata,
   output logic                        o_reg_rvalid,
   // error report request to core
   output logic                        o_err_req,
   output aesr_pkg::aesr_err_req_t     o_err_info,
   input  wire logic                   i_err_ack,
   // slot event requests to core
   output logic [4:0]                  o_slot_req,
   output logic [4:0]                  o_slot_number,
   input  wire logic [4:0]             i_slot_ack,
   // pending indication
   output logic                        o_err_pending
);

   logic [31:0]              err_ctrl;
   logic [31:0]              err_attr;
   logic [31:0]              err_hdr [4];
   logic [31:0]              err_prefix;
   logic [31:0]              slot_ctrl;
   aesr_pkg::aesr_state_t    state;
   aesr_pkg::aesr_state_t    next_state;

   // address decode
   wire wr_ctrl   = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_CTRL);
   wire wr_attr   = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_ATTR);
   wire wr_prefix = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_PREFIX);
   wire wr_slot   = i_reg_write & (i_reg_addr == aesr_pkg::OFS_SLOT_EVENT);
   wire [3:0] wr_hdr;
   assign wr_hdr[0] = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_HDR0);
   assign wr_hdr[1] = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_HDR1);
   assign wr_hdr[2] = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_HDR2);
   assign wr_hdr[3] = i_reg_write & (i_reg_addr == aesr_pkg::OFS_ERR_HDR3);

   // trigger is write-one-to-set; completion clears it
   wire trig_set  = wr_ctrl & i_reg_wdata[aesr_pkg::CTRL_TRIGGER];
   wire trig_done = (state == aesr_pkg::ST_WAIT) & i_err_ack;
   wire trig_now  = err_ctrl[aesr_pkg::CTRL_TRIGGER];
   wire next_trig = trig_set | (trig_now & ~trig_done);

   // non-trigger control fields; reserved bits masked off
   wire [31:0] ctrl_wmask  = aesr_pkg::MASK_ERR_CTRL;
   wire [31:0] ctrl_fields = wr_ctrl ? (i_reg_wdata & ctrl_wmask) : err_ctrl;
   wire [31:0] next_ctrl   = {ctrl_fields[31:1], next_trig};

   // error request state machine
   always_comb begin
      case (state)
         aesr_pkg::ST_IDLE: next_state = trig_now ? aesr_pkg::ST_SEND : aesr_pkg::ST_IDLE;
         aesr_pkg::ST_SEND: next_state = aesr_pkg::ST_WAIT;
         aesr_pkg::ST_WAIT: next_state = i_err_ack ? aesr_pkg::ST_IDLE : aesr_pkg::ST_WAIT;
         default:           next_state = aesr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state    <= aesr_pkg::ST_IDLE;
         err_ctrl <= aesr_pkg::RESET_WORD;
      end else begin
         state    <= next_state;
         err_ctrl <= next_ctrl;
      end
   end

   // attribute register, reserved high bits held zero
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         err_attr <= aesr_pkg::RESET_WORD;
      end else if (wr_attr) begin
         err_attr <= i_reg_wdata & aesr_pkg::MASK_ERR_ATTR;
      end
   end

   // header dwords and prefix word
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         for (int k = 0; k < 4; k++) begin
            err_hdr[k] <= aesr_pkg::RESET_WORD;
         end
         err_prefix <= aesr_pkg::RESET_WORD;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (wr_hdr[k]) begin
               err_hdr[k] <= i_reg_wdata;
            end
         end
         if (wr_prefix) begin
            err_prefix <= i_reg_wdata;
         end
      end
   end

   // attributes forwarded: supported bits only, later ones held back
   wire [13:0] attr_fwd = err_attr[aesr_pkg::ATTR_WIDTH-1:0]
                          & aesr_pkg::ATTR_SUPPORTED;
   wire        vf_act   = err_ctrl[aesr_pkg::CTRL_VIRTUAL_FUNCTION_ACTIVE];
   // no header or prefix logging for virtual function errors
   wire        log_hdr  = err_ctrl[aesr_pkg::CTRL_LOG_HEADER] & ~vf_act;
   wire        log_pfx  = err_ctrl[aesr_pkg::CTRL_LOG_PREFIX] & ~vf_act;
   wire [10:0] vf_idx   = vf_act ? err_ctrl[aesr_pkg::CTRL_VF_MSB:aesr_pkg::CTRL_VF_LSB]
                                 : 11'h000;

   aesr_pkg::aesr_err_req_t next_info;
   always_comb begin
      next_info.slot_number             = err_ctrl[aesr_pkg::CTRL_SLOT_MSB:aesr_pkg::CTRL_SLOT_LSB];
      next_info.virtual_function_index  = vf_idx;
      next_info.virtual_function_active = vf_act;
      next_info.physical_function_index = err_ctrl[aesr_pkg::CTRL_PF_MSB:aesr_pkg::CTRL_PF_LSB];
      next_info.log_prefix              = log_pfx;
      next_info.log_header              = log_hdr;
      next_info.error_type_attributes   = attr_fwd;
      next_info.error_header_dword      = log_hdr ? {err_hdr[3], err_hdr[2], err_hdr[1], err_hdr[0]}
                                                  : 128'h0;
      next_info.error_prefix_word       = log_pfx ? err_prefix : 32'h0000_0000;
   end

   // request to core held from send until ack
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_err_req     <= 1'b0;
         o_err_info    <= '0;
         o_err_pending <= 1'b0;
      end else begin
         o_err_req     <= (next_state == aesr_pkg::ST_SEND) | (next_state == aesr_pkg::ST_WAIT);
         o_err_pending <= next_trig;
         if (state == aesr_pkg::ST_IDLE) begin
            o_err_info <= next_info;
         end
      end
   end

   // slot event bits, each forwarded then cleared
   logic [4:0] slot_bits;
   genvar g;
   generate
      for (g = 0; g < aesr_pkg::SLOT_EVT_COUNT; g++) begin : g_slot
         aesr_slot_event u_evt (
            .i_core_clk (i_core_clk),
            .i_reset    (i_reset),
            .i_set      (wr_slot & i_reg_wdata[g]),
            .i_clear    (1'b0),
            .i_ack      (i_slot_ack[g]),
            .o_req      (slot_bits[g])
         );
      end
   endgenerate

   // remaining slot fields kept as plain storage
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         slot_ctrl <= aesr_pkg::RESET_WORD;
      end else if (wr_slot) begin
         slot_ctrl <= i_reg_wdata & aesr_pkg::MASK_SLOT_EVT;
      end
   end

   wire [31:0] slot_word = {slot_ctrl[31:aesr_pkg::SLOT_EVT_COUNT], slot_bits};

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_slot_req    <= 5'h00;
         o_slot_number <= 5'h00;
      end else begin
         o_slot_req    <= slot_bits & ~i_slot_ack;
         o_slot_number <= slot_ctrl[aesr_pkg::SLOT_NUM_MSB:aesr_pkg::SLOT_NUM_LSB];
      end
   end

   // read mux; unmapped offsets read zero
   logic [31:0] rd_sel;
   always_comb begin
      case (i_reg_addr)
         aesr_pkg::OFS_ERR_CTRL:   rd_sel = err_ctrl;
         aesr_pkg::OFS_ERR_ATTR:   rd_sel = err_attr;
         aesr_pkg::OFS_ERR_HDR0:   rd_sel = err_hdr[0];
         aesr_pkg::OFS_ERR_HDR1:   rd_sel = err_hdr[1];
         aesr_pkg::OFS_ERR_HDR2:   rd_sel = err_hdr[2];
         aesr_pkg::OFS_ERR_HDR3:   rd_sel = err_hdr[3];
         aesr_pkg::OFS_ERR_PREFIX: rd_sel = err_prefix;
         aesr_pkg::OFS_SLOT_EVENT: rd_sel = slot_word;
         default:                  rd_sel = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_reg_rdata  <= 32'h0000_0000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rdata  <= i_reg_read ? rd_sel : 32'h0000_0000;
         o_reg_rvalid <= i_reg_read;
      end
   end

endmodule

// ---- aesr_regs_checker.sv ----
// checker of request handshakes and register fields
module aesr_regs_checker (
   // observed ports
   input wire logic                    i_core_clk,
   input wire logic                    i_reset,
   input wire logic                    i_reg_write,
   input wire logic                    i_reg_read,
   input wire logic [7:0]              i_reg_addr,
   input wire logic [31:0]             i_reg_wdata,
   input wire logic [31:0]             o_reg_rdata,
   input wire logic                    o_reg_rvalid,
   input wire logic                    o_err_req,
   input wire aesr_pkg::aesr_err_req_t o_err_info,
   input wire logic                    i_err_ack,
   input wire logic [4:0]              o_slot_req,
   input wire logic [4:0]              i_slot_ack,
   input wire logic                    o_err_pending
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   wire logic trig_wr = i_reg_write && i_reg_addr == 8'h10 && i_reg_wdata[0];
   wire logic slot_wr = i_reg_write && i_reg_addr == 8'h2C;
   trig_start_a: assert property (trig_wr && !o_err_pending |-> ##2 o_err_req)
      else $error("no report request after trigger");
   pend_set_a: assert property (trig_wr |=> o_err_pending)
      else $error("pending flag not set by trigger");
   req_hold_a: assert property (o_err_req && !i_err_ack |=> o_err_req)
      else $error("report request dropped before ack");
   ack_done_a: assert property (o_err_req && i_err_ack && !trig_wr |=>
      !o_err_req ##1 (!o_err_pending || $past(trig_wr)))
      else $error("report not closed after ack");
   attr_mask_a: assert property (o_err_req |-> o_err_info[173:166] == 8'h00)
      else $error("unsupported error type forwarded");
   vf_zero_a: assert property (o_err_req && !o_err_info.virtual_function_active
      |-> o_err_info.virtual_function_index == 11'h000)
      else $error("function index without active flag");
   attr_rsvd_a: assert property (o_reg_rvalid && $past(i_reg_addr) == 8'h14
      |-> o_reg_rdata[31:14] == 18'h00000)
      else $error("reserved attribute bits read nonzero");
   slot_req_a: assert property (slot_wr && i_reg_wdata[0] && !o_slot_req[0]
      |-> ##2 o_slot_req[0])
      else $error("slot event not forwarded");
   slot_clr_a: assert property (o_slot_req[1] && i_slot_ack[1] && !slot_wr
      |=> !o_slot_req[1])
      else $error("slot event not cleared after ack");
   cover property (o_err_req && i_err_ack);
   cover property (o_err_req && o_err_info.virtual_function_active);
   cover property (o_slot_req == 5'h1F);
endmodule

bind aesr_regs aesr_regs_checker chk_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
   .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .o_err_req(o_err_req), .o_err_info(o_err_info), .i_err_ack(i_err_ack),
   .o_slot_req(o_slot_req), .i_slot_ack(i_slot_ack), .o_err_pending(o_err_pending));

// ---- aesr_core_model.sv ----
// behavioural hard protocol core answering request levels
module aesr_core_model (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   // answer latency in cycles
   input  wire logic [3:0] i_delay,
   // requests from the block and answers to it
   input  wire logic       i_err_req,
   input  wire logic [4:0] i_slot_req,
   output logic            o_err_ack,
   output logic [4:0]      o_slot_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   wire logic busy = (i_err_req && !o_err_ack) || (|(i_slot_req & ~o_slot_ack));
   always_ff @(posedge i_core_clk) begin
      o_err_ack <= 1'b0;
      o_slot_ack <= 5'h00;
      wait_cnt <= busy ? wait_cnt + 4'h1 : 4'h0;
      if (i_reset) begin
         wait_cnt <= 4'h0;
      end else if (busy && wait_cnt >= i_delay) begin
         o_err_ack <= i_err_req && !o_err_ack;
         o_slot_ack <= i_slot_req & ~o_slot_ack;
         wait_cnt <= 4'h0;
      end
   end
endmodule

// ---- testbench.sv ----
// self-checking bench for the request register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0]  dly = 4'h0;
   logic [31:0] rdat;
   logic        rv, ereq, eack, epend;
   logic [4:0]  sreq, snum, sack;
   aesr_pkg::aesr_err_req_t info;
   int bad_count = 0;
   int compares = 0;
   aesr_regs dut_u (.i_core_clk(clk), .i_reset(rst), .i_reg_write(wr), .i_reg_read(rd),
      .i_reg_addr(adr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
      .o_err_req(ereq), .o_err_info(info), .i_err_ack(eack), .o_slot_req(sreq),
      .o_slot_number(snum), .i_slot_ack(sack), .o_err_pending(epend));
   aesr_core_model core_u (.i_core_clk(clk), .i_reset(rst), .i_delay(dly),
      .i_err_req(ereq), .i_slot_req(sreq), .o_err_ack(eack), .o_slot_ack(sack));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [199:0] got, input logic [199:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      wr <= 1'b1;
      adr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      rd <= 1'b1;
      adr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rv, 1'b1);
      chk(rdat, e);
      @(posedge clk);
   endtask
   task automatic wait_lvl(input int s, input logic lvl);
      logic v;
      for (int n = 0; n < 200; n++) begin
         v = (s < 5) ? sreq[s] : (s == 5) ? ereq : epend;
         if (v === lvl) break;
         @(posedge clk);
      end
      chk(v, lvl);
   endtask
   function automatic aesr_pkg::aesr_err_req_t exp_info(input logic [31:0] c, a, p,
         input logic [127:0] h);
      aesr_pkg::aesr_err_req_t x;
      x.slot_number = c[30:26];
      x.virtual_function_index = c[7] ? c[24:14] : 11'h000;
      x.virtual_function_active = c[7];
      x.physical_function_index = c[12:8];
      x.log_prefix = c[2] && !c[7];
      x.log_header = c[1] && !c[7];
      x.error_type_attributes = a[13:0] & 14'h003F;
      x.error_header_dword = (c[1] && !c[7]) ? h : 128'h0;
      x.error_prefix_word = (c[2] && !c[7]) ? p : 32'h0;
      return x;
   endfunction
   task automatic wrap_up();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      logic [31:0] c, a, p, d, m;
      logic [127:0] h;
      d = $urandom(33638);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 9; i++) rreg(8'h0C + 8'(4 * i), 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         d = $urandom();
         m = (i == 0) ? 32'h7DFF_DF86 : (i == 1) ? 32'h3FFF : (i == 7) ? 32'h3FE0 : '1;
         wreg(8'h10 + 8'(4 * i), d & ((i == 0) ? 32'hFFFF_FFFE : (i == 7) ? 32'hFFFF_FFE0 : '1));
         rreg(8'h10 + 8'(4 * i), d & m);
      end
      wreg(8'h30, d);
      rreg(8'h30, 32'h0);
      $display("test register access done");
      for (int i = 0; i < 14; i++) begin
         a = ($urandom() & 32'hFFFF_C000) | (32'h1 << i);
         wreg(8'h14, a);
         for (int k = 0; k < 4; k++) begin
            h[32 * k +: 32] = $urandom();
            wreg(8'h18 + 8'(4 * k), h[32 * k +: 32]);
         end
         p = $urandom();
         wreg(8'h28, p);
         c = ($urandom() & 32'h7DFF_DF06) | ((i % 4 == 3) ? 32'h81 : 32'h1);
         dly <= 4'($urandom_range(0, 9));
         wreg(8'h10, c);
         wait_lvl(5, 1'b1);
         chk(info, exp_info(c, a, p, h));
         wait_lvl(6, 1'b0);
         rreg(8'h10, c & ~32'h1);
      end
      $display("test error reports done");
      for (int g = 0; g < 5; g++) begin
         d = (32'h1 << g) | ($urandom() & 32'h3E00);
         wreg(8'h2C, d);
         wait_lvl(g, 1'b1);
         chk(snum, d[13:9]);
         wait_lvl(g, 1'b0);
         rreg(8'h2C, d & 32'h3FE0);
      end
      wreg(8'h2C, 32'h1F);
      for (int g = 0; g < 5; g++) wait_lvl(g, 1'b1);
      for (int g = 0; g < 5; g++) wait_lvl(g, 1'b0);
      rreg(8'h2C, 32'h0);
      $display("test slot events done");
      wrap_up();
   end
endmodule
